//--- design/brt_pkg.sv
// Package of shared constants for the data-memory bus timing and remote select block.
package brt_pkg;
  // ----------------------------------------------------------------
  // Timing in half T-states (one half T-state is one sys_clk cycle).
  // ----------------------------------------------------------------
  localparam int unsigned HALF_NS = 4;
  localparam int unsigned SYS_PERIOD_NS = 4;
  localparam int unsigned HALF_CYC = (HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam logic [3:0] SHORT_HALVES = 4'h6;
  localparam logic [3:0] LONG_HALVES = 4'h8;
  localparam logic [3:0] ALE_FALL_HALF = 4'h1;
  localparam logic [3:0] RD_FALL_SHORT = 4'h2;
  localparam logic [3:0] RD_FALL_LONG = 4'h3;
  localparam logic [3:0] RD_RISE_SHORT = 4'h5;
  localparam logic [3:0] RD_RISE_LONG = 4'h7;
  // ----------------------------------------------------------------
  // Reset values and field positions.
  // ----------------------------------------------------------------
  localparam logic [1:0] CFG_SEL_IMEM = 2'h1;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [15:0] ZERO16 = 16'h0000;
  typedef enum logic [2:0] {
    BRT_IDLE = 3'b001,
    BRT_READ = 3'b010,
    BRT_WRITE = 3'b100
  } brt_state_t;
endpackage

//--- design/brt_imem.sv
// Instruction memory with registered read data, byte-lane writes.
`timescale 1ns/1ps
module brt_imem #(
  parameter int AW = 8
) (
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic wr_hi,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wr_data,
  output logic [15:0] rd_data
);
  logic [15:0] mem [0:(1<<AW)-1];

  // Write one byte lane; read data always comes out of a register.
  always_ff @(posedge sys_clk) begin
    if (wr_en && wr_hi) begin
      mem[addr][15:8] <= wr_data;
    end
    if (wr_en && !wr_hi) begin
      mem[addr][7:0] <= wr_data;
    end
    rd_data <= mem[addr];
  end
endmodule // brt_imem

//--- design/brt_top.sv
// Data-memory read timing, reset state of buses and remote instruction access.
`timescale 1ns/1ps
module brt_top #(
  parameter int IMEM_AW = 8
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic long_read_select,
  input wire logic rd_req,
  input wire logic wr_req,
  input wire logic [15:0] req_addr,
  input wire logic [7:0] req_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic idx_load,
  input wire logic [1:0] idx_sel,
  input wire logic [7:0] idx_data,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_data,
  input wire logic [15:0] prog_counter,
  input wire logic rem_imem_rd,
  input wire logic rem_imem_wr,
  input wire logic [7:0] rem_wdata,
  input wire logic remote_read_strobe_n,
  input wire logic buffered_read,
  output logic [15:0] addr_bus,
  output logic [7:0] ad_out,
  output logic ad_oe,
  output logic ale,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic busy,
  output logic [7:0] rd_data,
  output logic rd_done,
  output logic [31:0] index_regs,
  output logic [7:0] rem_rdata,
  output logic local_bus_grant,
  output logic imem_hi_sel
);
  logic rst_s1;
  logic rst_n;
  brt_pkg::brt_state_t state;
  logic [3:0] half_cnt;
  logic long_cyc;
  logic [15:0] imem_word;
  logic [3:0] last_half;
  logic [3:0] rd_fall;
  logic [3:0] rd_rise;
  logic rem_strobe_q;
  logic rem_acc_pend;
  logic rem_acc_hi;

  // ----------------------------------------------------------------
  // Reset release.
  // ----------------------------------------------------------------
  // Two-flop release so deassertion is clean against sys_clk.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // ----------------------------------------------------------------
  // Data memory bus cycle sequencer.
  // ----------------------------------------------------------------
  // Cycle length is latched at the start so a mode write mid-cycle is safe.
  assign last_half = long_cyc ? brt_pkg::LONG_HALVES - 4'h1 : brt_pkg::SHORT_HALVES - 4'h1;
  assign rd_fall = long_cyc ? brt_pkg::RD_FALL_LONG : brt_pkg::RD_FALL_SHORT;
  assign rd_rise = long_cyc ? brt_pkg::RD_RISE_LONG : brt_pkg::RD_RISE_SHORT;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= brt_pkg::BRT_IDLE;
      half_cnt <= 4'h0;
      long_cyc <= 1'b0;
      busy <= 1'b0;
    end else begin
      case (state)
        brt_pkg::BRT_IDLE: begin
          half_cnt <= 4'h0;
          if (rd_req) begin
            state <= brt_pkg::BRT_READ;
            long_cyc <= long_read_select;
            busy <= 1'b1;
          end else if (wr_req) begin
            state <= brt_pkg::BRT_WRITE;
            long_cyc <= 1'b0;
            busy <= 1'b1;
          end
        end
        brt_pkg::BRT_READ, brt_pkg::BRT_WRITE: begin
          half_cnt <= half_cnt + 4'h1;
          if (half_cnt == last_half) begin
            state <= brt_pkg::BRT_IDLE;
            busy <= 1'b0;
          end
        end
        default: state <= brt_pkg::BRT_IDLE;
      endcase
    end
  end

  // Strobes and buses; AD is released for reads and re-driven half a T-state after READ rises.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_bus <= brt_pkg::ZERO16;
      ad_out <= brt_pkg::ZERO8;
      ad_oe <= 1'b1;
      ale <= 1'b0;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      rd_data <= brt_pkg::ZERO8;
      rd_done <= 1'b0;
    end else begin
      rd_done <= 1'b0;
      if (state == brt_pkg::BRT_IDLE) begin
        ale <= rd_req | wr_req;
        if (rd_req | wr_req) begin
          addr_bus <= req_addr;
          ad_out <= req_addr[7:0];
        end
      end else begin
        if (half_cnt == brt_pkg::ALE_FALL_HALF - 4'h1) begin
          ale <= 1'b0;
        end
        if (state == brt_pkg::BRT_READ) begin
          if (half_cnt == rd_fall - 4'h1) begin
            ad_oe <= 1'b0;
            read_strobe_n <= 1'b0;
          end
          if (half_cnt == rd_rise - 4'h1) begin
            read_strobe_n <= 1'b1;
            rd_data <= mem_rdata;
            rd_done <= 1'b1;
          end
          if (half_cnt == rd_rise) begin
            ad_oe <= 1'b1;
          end
        end else begin
          if (half_cnt == brt_pkg::RD_FALL_SHORT - 4'h1) begin
            ad_out <= req_wdata;
            write_strobe_n <= 1'b0;
          end
          if (half_cnt == brt_pkg::RD_RISE_SHORT - 4'h1) begin
            write_strobe_n <= 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Index registers.
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      index_regs <= 32'h00000000;
    end else if (idx_load) begin
      index_regs[idx_sel*8 +: 8] <= idx_data;
    end
  end

  // ----------------------------------------------------------------
  // Remote instruction memory access.
  // ----------------------------------------------------------------
  // Byte pointer; a config write selecting instruction memory wins over a toggle.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      imem_hi_sel <= 1'b0;
    end else if (cfg_wr && cfg_data[1:0] == brt_pkg::CFG_SEL_IMEM) begin
      imem_hi_sel <= 1'b0;
    end else if (rem_imem_rd || rem_imem_wr) begin
      imem_hi_sel <= ~imem_hi_sel;
    end
  end

  brt_imem #(.AW(IMEM_AW)) u_imem (
    .sys_clk(sys_clk),
    .wr_en(rem_imem_wr),
    .wr_hi(imem_hi_sel),
    .addr(prog_counter[IMEM_AW-1:0]),
    .wr_data(rem_wdata),
    .rd_data(imem_word)
  );

  // Read data lags one cycle behind the request, so the byte choice is held.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_acc_pend <= 1'b0;
      rem_acc_hi <= 1'b0;
      rem_rdata <= brt_pkg::ZERO8;
    end else begin
      rem_acc_pend <= rem_imem_rd;
      rem_acc_hi <= imem_hi_sel;
      if (rem_acc_pend) begin
        rem_rdata <= rem_acc_hi ? imem_word[15:8] : imem_word[7:0];
      end
    end
  end

  // Grant held through a buffered read, dropped on the strobe's rising edge.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_strobe_q <= 1'b1;
      local_bus_grant <= 1'b0;
    end else begin
      rem_strobe_q <= remote_read_strobe_n;
      if (buffered_read && !remote_read_strobe_n) begin
        local_bus_grant <= 1'b1;
      end else if (remote_read_strobe_n && !rem_strobe_q) begin
        local_bus_grant <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  property p_long_len;
    @(posedge sys_clk) disable iff (!rst_n)
      (state == brt_pkg::BRT_IDLE && rd_req && long_read_select)
      |=> (state == brt_pkg::BRT_READ)[*8] ##1 (state == brt_pkg::BRT_IDLE);
  endproperty
  a_long_len: assert property (p_long_len) else $error("long read not 8 halves");

  property p_long_gap;
    @(posedge sys_clk) disable iff (!rst_n)
      (state == brt_pkg::BRT_IDLE && rd_req && long_read_select)
      |=> ##1 !ale ##1 read_strobe_n ##1 !read_strobe_n;
  endproperty
  a_long_gap: assert property (p_long_gap) else $error("long read strobe gap wrong");

  property p_short_len;
    @(posedge sys_clk) disable iff (!rst_n)
      (state == brt_pkg::BRT_IDLE && rd_req && !long_read_select)
      |=> (state == brt_pkg::BRT_READ)[*6] ##1 (state == brt_pkg::BRT_IDLE);
  endproperty
  a_short_len: assert property (p_short_len) else $error("short read not 6 halves");

  property p_reset_zero;
    @(posedge sys_clk) $rose(rst_n) |->
      addr_bus == 16'h0000 && ad_out == 8'h00 && index_regs == 32'h00000000;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("buses not zero after reset");

  property p_sel_low;
    @(posedge sys_clk) disable iff (!rst_n)
      (cfg_wr && cfg_data[1:0] == brt_pkg::CFG_SEL_IMEM) |=> !imem_hi_sel;
  endproperty
  a_sel_low: assert property (p_sel_low) else $error("select did not point at low byte");

  property p_ad_gap;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(read_strobe_n) && state == brt_pkg::BRT_READ |-> !ad_oe ##1 ad_oe;
  endproperty
  a_ad_gap: assert property (p_ad_gap) else $error("AD re-enabled without gap");

  property p_grant_drop;
    @(posedge sys_clk) disable iff (!rst_n)
      (remote_read_strobe_n && !rem_strobe_q) |=> !local_bus_grant;
  endproperty
  a_grant_drop: assert property (p_grant_drop) else $error("grant not dropped");

  property p_toggle;
    @(posedge sys_clk) disable iff (!rst_n)
      (rem_imem_rd && !cfg_wr && !imem_hi_sel) |=> imem_hi_sel;
  endproperty
  a_toggle: assert property (p_toggle) else $error("high byte not next");

  c_long: cover property (@(posedge sys_clk) rd_req && long_read_select && !busy);
  c_short: cover property (@(posedge sys_clk) rd_done && !long_cyc);
  c_grant: cover property (@(posedge sys_clk) $fell(local_bus_grant));
endmodule // brt_top

//--- tb/brt_mem_model.sv
// Behavioural static data memory that answers the data read strobe.
`timescale 1ns/1ps
module brt_mem_model (
  input wire logic [15:0] addr_bus,
  input wire logic read_strobe_n,
  output logic [7:0] mem_rdata
);
  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // Outside the strobe the bus shows the inverse, so a late sample cannot match by luck.
  always_comb begin
    if (!read_strobe_n) begin
      mem_rdata = addr_bus[7:0] ^ addr_bus[15:8] ^ 8'h5a;
    end else begin
      mem_rdata = ~(addr_bus[7:0] ^ addr_bus[15:8] ^ 8'h5a);
    end
  end
endmodule // brt_mem_model

//--- tb/brt_top_tb.sv
// Self-checking testbench for the bus read timing and remote select block.
`timescale 1ns/1ps
module brt_top_tb;
  logic sys_clk, nrst, long_read_select, rd_req, wr_req, idx_load, cfg_wr;
  logic rem_imem_rd, rem_imem_wr, remote_read_strobe_n, buffered_read;
  logic [15:0] req_addr, prog_counter, addr_bus;
  logic [7:0] req_wdata, mem_rdata, idx_data, cfg_data, rem_wdata, ad_out, rd_data, rem_rdata;
  logic [1:0] idx_sel;
  logic [31:0] index_regs;
  logic ad_oe, ale, read_strobe_n, write_strobe_n, busy, rd_done, local_bus_grant, imem_hi_sel;
  int errors, cmp_count;

  brt_top u_brt_top (.sys_clk(sys_clk), .nrst(nrst), .long_read_select(long_read_select),
    .rd_req(rd_req), .wr_req(wr_req), .req_addr(req_addr), .req_wdata(req_wdata),
    .mem_rdata(mem_rdata), .idx_load(idx_load), .idx_sel(idx_sel), .idx_data(idx_data),
    .cfg_wr(cfg_wr), .cfg_data(cfg_data), .prog_counter(prog_counter),
    .rem_imem_rd(rem_imem_rd), .rem_imem_wr(rem_imem_wr), .rem_wdata(rem_wdata),
    .remote_read_strobe_n(remote_read_strobe_n), .buffered_read(buffered_read),
    .addr_bus(addr_bus), .ad_out(ad_out), .ad_oe(ad_oe), .ale(ale),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .busy(busy),
    .rd_data(rd_data), .rd_done(rd_done), .index_regs(index_regs), .rem_rdata(rem_rdata),
    .local_bus_grant(local_bus_grant), .imem_hi_sel(imem_hi_sel));
  brt_mem_model u_brt_mem_model (.addr_bus(addr_bus), .read_strobe_n(read_strobe_n),
    .mem_rdata(mem_rdata));

  // One half T-state per clock cycle.
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Reset is held for ten cycles; three edges pass before the first request.
  task automatic do_reset();
    @(negedge sys_clk);
    nrst = 1'b0;
    repeat (10) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic pulse(ref logic s);
    @(negedge sys_clk);
    s = 1'b1;
    @(negedge sys_clk);
    s = 1'b0;
  endtask

  // One data read; edge positions are counted in cycles after the take edge.
  task automatic do_read(input logic mode, input logic [15:0] a);
    int af, rf, rr, bf, ok, dn;
    af = -1; rf = -1; rr = -1; bf = -1; ok = -1; dn = -1;
    @(negedge sys_clk);
    long_read_select = mode;
    req_addr = a;
    rd_req = 1'b1;
    @(negedge sys_clk);
    rd_req = 1'b0;
    for (int k = 0; k < 16; k++) begin
      if (k > 0) @(negedge sys_clk);
      if (af < 0 && ale === 1'b0) af = k;
      if (rf < 0 && read_strobe_n === 1'b0) rf = k;
      if (rf >= 0 && rr < 0 && read_strobe_n === 1'b1) rr = k;
      if (rr >= 0 && ok < 0 && ad_oe === 1'b1) ok = k;
      if (dn < 0 && rd_done === 1'b1) dn = k;
      if (bf < 0 && busy === 1'b0) bf = k;
    end
    chk(rf - af, mode ? 2 : 1, "ale to read gap");
    chk(bf, mode ? 8 : 6, "read length");
    chk(dn, mode ? 7 : 5, "done cycle");
    chk(ok - rr, 1, "ad reenable gap");
    chk(rd_data, a[7:0] ^ a[15:8] ^ 8'h5a, "read data");
  endtask

  // Index registers loaded, then a mid-run reset clears them and the buses.
  task automatic sc_reset_state();
    for (int i = 0; i < 4; i++) begin
      @(negedge sys_clk);
      idx_sel = i[1:0];
      idx_data = 8'(8'h11 * (i + 1));
      pulse(idx_load);
    end
    chk(index_regs, 32'h44332211, "index load");
    do_reset();
    chk(index_regs, 32'h0, "index reset");
    chk(addr_bus, 16'h0, "addr reset");
    chk(ad_out, 8'h0, "ad reset");
  endtask

  // Write low and high byte, step the pointer with a read, reselect, read both back.
  task automatic sc_imem();
    prog_counter = 16'h0012;
    cfg_data = 8'hfd;
    pulse(cfg_wr);
    rem_wdata = 8'ha5;
    pulse(rem_imem_wr);
    chk(imem_hi_sel, 1'b1, "pointer after low");
    rem_wdata = 8'h3c;
    pulse(rem_imem_wr);
    pulse(rem_imem_rd);
    pulse(cfg_wr);
    chk(imem_hi_sel, 1'b0, "pointer after select");
    pulse(rem_imem_rd);
    @(negedge sys_clk);
    chk(rem_rdata, 8'ha5, "low byte read");
    pulse(rem_imem_rd);
    @(negedge sys_clk);
    chk(rem_rdata, 8'h3c, "high byte read");
  endtask

  // Buffered remote read: grant drops once the remote strobe rises.
  task automatic sc_grant();
    int n;
    n = 0;
    @(negedge sys_clk);
    buffered_read = 1'b1;
    remote_read_strobe_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk(local_bus_grant, 1'b1, "grant up");
    remote_read_strobe_n = 1'b1;
    while (local_bus_grant !== 1'b0 && n < 3) begin
      @(negedge sys_clk);
      n++;
    end
    chk(local_bus_grant, 1'b0, "grant drop");
    chk(n, 1, "grant drop cycle");
    buffered_read = 1'b0;
  endtask

  // A write runs six half T-states and pulses the write strobe.
  task automatic sc_write();
    int lo;
    lo = 0;
    @(negedge sys_clk);
    req_addr = 16'h0040;
    req_wdata = 8'h77;
    wr_req = 1'b1;
    @(negedge sys_clk);
    wr_req = 1'b0;
    for (int k = 1; k < 6; k++) begin
      if (write_strobe_n === 1'b0) lo++;
      @(negedge sys_clk);
    end
    chk(lo, 3, "write strobe");
    chk(ad_out, 8'h77, "write data");
    chk(ad_oe, 1'b1, "write drives ad");
    chk(busy, 1'b1, "write still busy");
    @(negedge sys_clk);
    chk(busy, 1'b0, "write length");
  endtask

  initial begin
    errors = 0;
    cmp_count = 0;
    {nrst, long_read_select, rd_req, wr_req, idx_load, cfg_wr} = '0;
    {rem_imem_rd, rem_imem_wr, buffered_read, idx_sel} = '0;
    remote_read_strobe_n = 1'b1;
    {req_addr, prog_counter, req_wdata, idx_data, cfg_data, rem_wdata} = '0;
    do_reset();
    chk(read_strobe_n, 1'b1, "strobe idle");
    do_read(1'b0, 16'h1234);
    do_read(1'b1, 16'hbeef);
    do_read(1'b1, 16'h00ff);
    do_read(1'b0, 16'h8001);
    sc_write();
    sc_reset_state();
    do_read(1'b0, 16'h0f0f);
    sc_imem();
    sc_grant();
    end_sim();
  end

  // Hang guard; far beyond the length of the sequence above.
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    end_sim();
  end
endmodule // brt_top_tb
